/* File: design/dtc_pkg.sv */
package dtc_pkg;
    // widths
    localparam int CNT_W   = 8;
    localparam int ADDR_W  = 4;
    localparam int BUS_W   = 16;
    localparam int TAP_N   = 12;
    localparam int DIV_W   = 13;
    localparam int SYNC_N  = 2;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_COUNT_ONE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_COUNT_TWO = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_MATCH_ONE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_MATCH_TWO = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CLK_SEL   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_MODE_CTL  = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_WAVE_CTL  = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_OSC_SEL   = 4'h7;

    // field positions
    localparam int MODE_RUN_ONE   = 0;
    localparam int MODE_RUN_TWO   = 1;
    localparam int MODE_CASCADE   = 2;
    localparam int WAVE_EN        = 0;
    localparam int WAVE_INV       = 1;
    localparam int WAVE_SET       = 2;
    localparam int WAVE_CLR       = 3;
    localparam int WAVE_STRIDE    = 4;
    localparam int CLK_SEL_W      = 4;
    localparam int OSC_FAST_BIT   = 0;

    // count clock select codes
    localparam logic [CLK_SEL_W-1:0] SEL_FALL      = 4'h0;
    localparam logic [CLK_SEL_W-1:0] SEL_RISE      = 4'h1;
    localparam logic [CLK_SEL_W-1:0] SEL_DIV_FIRST = 4'h6;
    localparam logic [CLK_SEL_W-1:0] SEL_DIV_LAST  = 4'he;
    localparam logic [CLK_SEL_W-1:0] SEL_DIV_2K    = 4'hf;
    localparam int                   TAP_2K        = 10;

    // reset values
    localparam logic [7:0]       CLK_SEL_RST  = 8'h00;
    localparam logic [7:0]       MODE_RST     = 8'h00;
    localparam logic [7:0]       WAVE_RST     = 8'h00;
    localparam logic             OSC_RST      = 1'b0;
    localparam logic [CNT_W-1:0] COUNT_RST    = 8'h00;
    localparam logic [CNT_W-1:0] COUNT_TOP    = 8'hff;
    localparam logic [7:0]       WAVE_RD_MASK = 8'h33;

    // timing
    localparam longint CORE_CLK_HZ      = 100000000;
    localparam int     RES_COUNT_CLOCKS = 1;
endpackage : dtc_pkg

/* File: design/dtc_prescaler.sv */
`timescale 1ns/1ns
module dtc_prescaler (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // tick carrier
    dtc_tick_if.src   tk
);
    import dtc_pkg::*;

    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] next_div_cnt;
    logic [TAP_N-1:0] tick_q;
    logic [TAP_N-1:0] next_tick;

    always_comb begin
        next_div_cnt = div_cnt + 1'b1;
    end

    // tap i divides by 2^(i+1); slow mode halves every tap
    genvar gi;
    generate
        for (gi = 0; gi < TAP_N; gi++) begin : g_tap
            localparam logic [DIV_W-1:0] MASK_FAST = DIV_W'((1 << (gi + 1)) - 1);
            localparam logic [DIV_W-1:0] MASK_SLOW = DIV_W'((1 << (gi + 2)) - 1);
            always_comb begin
                next_tick[gi] = tk.osc_fast ? ((div_cnt & MASK_FAST) == MASK_FAST)
                                            : ((div_cnt & MASK_SLOW) == MASK_SLOW);
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            div_cnt <= '0;
            tick_q  <= '0;
        end else begin
            div_cnt <= next_div_cnt;
            tick_q  <= next_tick;
        end
    end

    assign tk.tick = tick_q;

    // fast first tap every other cycle
    a_fast_tap_rate: assert property (@(posedge core_clk) disable iff (!rst_b)
        tk.osc_fast && $stable(tk.osc_fast) && tick_q[0] |=> !tick_q[0] ##1 (tick_q[0] || !tk.osc_fast))
        else $error("fast divide-by-two tap not periodic");
    a_slow_tap_rate: assert property (@(posedge core_clk) disable iff (!rst_b)
        !tk.osc_fast && !$past(tk.osc_fast) && tick_q[0]
        |=> !tick_q[0] ##1 (!tick_q[0] || tk.osc_fast) ##1 (!tick_q[0] || tk.osc_fast))
        else $error("slow divide tap too fast");
endmodule : dtc_prescaler

/* File: design/dtc_tick_if.sv */
`timescale 1ns/1ns
interface dtc_tick_if;
    logic                     osc_fast;
    logic [dtc_pkg::TAP_N-1:0] tick;
    modport src (input osc_fast, output tick);
    modport dst (output osc_fast, input tick);
endinterface : dtc_tick_if

/* File: design/dtc_timer.sv */
`timescale 1ns/1ns
// Functional notes
// - in independent mode compare each counter with its match value; equality raises channel interrupt
// - independent mode match values accept 00h through ffh
// - cascaded mode both match bytes form one 16-bit value
// - match values are not touched by reset
// - in dual mode each counter reads as one byte
// - in cascaded mode both counters read as one halfword
// - reset clears both counters to zero
// - event mode counts one per selected external input edge (falling or rising)
// - square-wave mode toggles output pin on each match
// - cascaded wave width resolution is one count clock
// - oscillation mode bit sets prescaler base; cleared doubles all periods
// - four-bit select: pin falling, pin rising, divide 2..512 or 2048
// - output flop set and reset commands act on write, read zero
module dtc_timer (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    // register access
    input  wire logic [dtc_pkg::ADDR_W-1:0]  bus_addr,
    input  wire logic                        bus_wr,
    input  wire logic                        bus_rd,
    input  wire logic                        bus_half,
    input  wire logic [dtc_pkg::BUS_W-1:0]   bus_wdata,
    output logic      [dtc_pkg::BUS_W-1:0]   bus_rdata,
    output logic                             bus_rvalid,
    // event pins
    input  wire logic                        event_in_one,
    input  wire logic                        event_in_two,
    // wave pins
    output logic                             wave_out_one,
    output logic                             wave_out_two,
    // interrupt requests
    output logic                             match_irq_one,
    output logic                             match_irq_two
);
    import dtc_pkg::*;

    dtc_tick_if tk ();

    dtc_prescaler u_pre (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tk       (tk)
    );

    logic [1:0][CNT_W-1:0] cnt;
    logic [1:0][CNT_W-1:0] next_cnt;
    logic [1:0][CNT_W-1:0] match_val;
    logic [1:0][CNT_W-1:0] next_match_val;
    logic [7:0]            count_clock_select;
    logic [7:0]            next_count_clock_select;
    logic [7:0]            timer_mode_control;
    logic [7:0]            next_timer_mode_control;
    logic [7:0]            wave_output_control;
    logic [7:0]            next_wave_output_control;
    logic                  osc_speed_select;
    logic                  next_osc_speed_select;
    logic [1:0]            flop;
    logic [1:0]            next_flop;
    logic [1:0]            irq_q;
    logic [1:0]            next_irq;
    logic [1:0]            wave_q;
    logic [1:0]            next_wave;
    logic [BUS_W-1:0]      rdata_q;
    logic [BUS_W-1:0]      next_rdata;
    logic                  rvalid_q;
    logic                  next_rvalid;
    logic [1:0]            ch_tick;
    logic [1:0]            pin_raw;
    logic                  cascade;
    logic [1:0]            run;
    logic [1:0]            match_hit;
    logic                  casc_match;
    logic [1:0]            ev;
    logic                  byte_wr;

    assign tk.osc_fast = osc_speed_select;
    assign pin_raw     = {event_in_two, event_in_one};

    // per channel: pin synchroniser, edge detect, count clock select
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_ch
            logic [CLK_SEL_W-1:0] sel;
            logic [SYNC_N:0]      sync;
            logic [SYNC_N:0]      next_sync;
            logic                 rise;
            logic                 fall;
            always_comb begin
                next_sync = {sync[SYNC_N-1:0], pin_raw[gc]};
                sel       = count_clock_select[gc*CLK_SEL_W +: CLK_SEL_W];
                rise      = sync[SYNC_N-1] & ~sync[SYNC_N];
                fall      = ~sync[SYNC_N-1] & sync[SYNC_N];
                if (sel == SEL_FALL) begin
                    ch_tick[gc] = fall;
                end else if (sel == SEL_RISE) begin
                    ch_tick[gc] = rise;
                end else if (sel >= SEL_DIV_FIRST && sel <= SEL_DIV_LAST) begin
                    ch_tick[gc] = tk.tick[sel - SEL_DIV_FIRST];
                end else if (sel == SEL_DIV_2K) begin
                    ch_tick[gc] = tk.tick[TAP_2K];
                end else begin
                    ch_tick[gc] = 1'b0;
                end
            end
            always_ff @(posedge core_clk) begin
                if (!rst_b) begin
                    sync <= '0;
                end else begin
                    sync <= next_sync;
                end
            end
        end
    endgenerate

    always_comb begin
        next_count_clock_select  = count_clock_select;
        next_timer_mode_control  = timer_mode_control;
        next_wave_output_control = wave_output_control;
        next_osc_speed_select    = osc_speed_select;
        next_match_val           = match_val;
        next_cnt                 = cnt;
        next_flop                = flop;
        next_rdata               = rdata_q;
        byte_wr                  = bus_wr && !bus_half;
        cascade                  = timer_mode_control[MODE_CASCADE];
        run[0]                   = timer_mode_control[MODE_RUN_ONE];
        run[1]                   = cascade ? run[0] : timer_mode_control[MODE_RUN_TWO];
        casc_match               = {cnt[1], cnt[0]} == {match_val[1], match_val[0]};
        match_hit[0]             = cascade ? casc_match : (cnt[0] == match_val[0]);
        match_hit[1]             = !cascade && (cnt[1] == match_val[1]);
        ev                       = ch_tick & match_hit & run;

        if (byte_wr) begin
            case (bus_addr)
                OFS_MATCH_ONE: next_match_val[0] = bus_wdata[CNT_W-1:0];
                OFS_MATCH_TWO: next_match_val[1] = bus_wdata[CNT_W-1:0];
                OFS_CLK_SEL:   next_count_clock_select = bus_wdata[7:0];
                OFS_MODE_CTL:  next_timer_mode_control = bus_wdata[7:0];
                OFS_WAVE_CTL:  next_wave_output_control = bus_wdata[7:0] & WAVE_RD_MASK;
                OFS_OSC_SEL:   next_osc_speed_select = bus_wdata[OSC_FAST_BIT];
                default: begin
                end
            endcase
        end

        if (!run[0]) begin
            next_cnt[0] = COUNT_RST;
        end else if (ch_tick[0]) begin
            next_cnt[0] = match_hit[0] ? COUNT_RST : cnt[0] + 1'b1;
        end
        if (!run[1]) begin
            next_cnt[1] = COUNT_RST;
        end else if (cascade) begin
            if (ch_tick[0] && casc_match) begin
                next_cnt[1] = COUNT_RST;
            end else if (ch_tick[0] && cnt[0] == COUNT_TOP) begin
                next_cnt[1] = cnt[1] + 1'b1;
            end
        end else if (ch_tick[1]) begin
            next_cnt[1] = match_hit[1] ? COUNT_RST : cnt[1] + 1'b1;
        end

        for (int i = 0; i < 2; i++) begin
            if (ev[i] && wave_output_control[i*WAVE_STRIDE + WAVE_INV]) begin
                next_flop[i] = ~flop[i];
            end
            if (byte_wr && bus_addr == OFS_WAVE_CTL) begin
                if (bus_wdata[i*WAVE_STRIDE + WAVE_SET]) begin
                    next_flop[i] = 1'b1;
                end else if (bus_wdata[i*WAVE_STRIDE + WAVE_CLR]) begin
                    next_flop[i] = 1'b0;
                end
            end
            next_wave[i] = next_flop[i] & next_wave_output_control[i*WAVE_STRIDE + WAVE_EN];
        end
        next_irq    = ev;
        next_rvalid = bus_rd;

        if (bus_rd) begin
            next_rdata = '0;
            if (bus_half) begin
                if (bus_addr == OFS_COUNT_ONE) begin
                    next_rdata = {cnt[1], cnt[0]};
                end
            end else begin
                case (bus_addr)
                    OFS_COUNT_ONE: next_rdata = {8'h00, cnt[0]};
                    OFS_COUNT_TWO: next_rdata = {8'h00, cnt[1]};
                    OFS_MATCH_ONE: next_rdata = {8'h00, match_val[0]};
                    OFS_MATCH_TWO: next_rdata = {8'h00, match_val[1]};
                    OFS_CLK_SEL:   next_rdata = {8'h00, count_clock_select};
                    OFS_MODE_CTL:  next_rdata = {8'h00, timer_mode_control};
                    OFS_WAVE_CTL:  next_rdata = {8'h00, wave_output_control};
                    OFS_OSC_SEL:   next_rdata = {15'h0000, osc_speed_select};
                    default:       next_rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cnt                 <= '0;
            count_clock_select  <= CLK_SEL_RST;
            timer_mode_control  <= MODE_RST;
            wave_output_control <= WAVE_RST;
            osc_speed_select    <= OSC_RST;
            flop                <= '0;
            irq_q               <= '0;
            wave_q              <= '0;
            rdata_q             <= '0;
            rvalid_q            <= 1'b0;
        end else begin
            cnt                 <= next_cnt;
            count_clock_select  <= next_count_clock_select;
            timer_mode_control  <= next_timer_mode_control;
            wave_output_control <= next_wave_output_control;
            osc_speed_select    <= next_osc_speed_select;
            flop                <= next_flop;
            irq_q               <= next_irq;
            wave_q              <= next_wave;
            rdata_q             <= next_rdata;
            rvalid_q            <= next_rvalid;
        end
    end

    always_ff @(posedge core_clk) begin
        match_val <= next_match_val;
    end

    assign bus_rdata     = rdata_q;
    assign bus_rvalid    = rvalid_q;
    assign wave_out_one  = wave_q[0];
    assign wave_out_two  = wave_q[1];
    assign match_irq_one = irq_q[0];
    assign match_irq_two = irq_q[1];

    a_match_irq: assert property (@(posedge core_clk) disable iff (!rst_b)
        run[0] && ch_tick[0] && match_hit[0] |=> match_irq_one && cnt[0] == 8'h00)
        else $error("match did not raise channel one request");
    a_irq_needs_match: assert property (@(posedge core_clk) disable iff (!rst_b)
        match_irq_two |-> $past(cnt[1]) == $past(match_val[1]) && !$past(cascade))
        else $error("channel two request without match");
    a_match_byte_wr: assert property (@(posedge core_clk) disable iff (!rst_b)
        bus_wr && !bus_half && bus_addr == 4'h2 |=> match_val[0] == 8'($past(bus_wdata)))
        else $error("match byte write not stored");
    a_match_half_ign: assert property (@(posedge core_clk) disable iff (!rst_b)
        bus_wr && bus_half && !(bus_wr && !bus_half) |=> $stable(match_val))
        else $error("halfword write altered match value");
    a_count_reset: assert property (@(posedge core_clk)
        !rst_b |=> cnt == 16'h0000 && !match_irq_one && !wave_out_one)
        else $error("reset did not clear counters");
    a_byte_read: assert property (@(posedge core_clk) disable iff (!rst_b)
        bus_rd && !bus_half && bus_addr == 4'h1 |=> bus_rvalid && bus_rdata == {8'h00, $past(cnt[1])})
        else $error("byte counter read wrong");
    a_half_read: assert property (@(posedge core_clk) disable iff (!rst_b)
        bus_rd && bus_half && bus_addr == 4'h0 |=> bus_rdata == $past(cnt))
        else $error("halfword count read wrong");
    a_cmd_read_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        bus_rd && !bus_half && bus_addr == 4'h6 |=> bus_rdata[3:2] == 2'b00 && bus_rdata[7:6] == 2'b00)
        else $error("flop command bits read nonzero");
    a_event_count: assert property (@(posedge core_clk) disable iff (!rst_b)
        run[0] && !cascade && count_clock_select[3:0] == 4'h1 && $rose(g_ch[0].sync[1]) && !match_hit[0]
        |=> ##1 cnt[0] == $past(cnt[0], 2) + 8'h01)
        else $error("event edge not counted");
    a_cascade_carry: assert property (@(posedge core_clk) disable iff (!rst_b)
        run[0] && cascade && ch_tick[0] && cnt[0] == 8'hff && !casc_match
        |=> cnt[1] == $past(cnt[1]) + 8'h01 && cnt[0] == 8'h00)
        else $error("cascade carry lost");
    a_wave_toggle: assert property (@(posedge core_clk) disable iff (!rst_b)
        ev[0] && wave_output_control[1] && wave_output_control[0] && !(bus_wr && bus_addr == 4'h6)
        |=> wave_out_one != $past(flop[0]))
        else $error("wave output did not toggle");
    a_casc_two_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
        cascade && $past(cascade) |-> !match_irq_two)
        else $error("channel two request in cascade");

    c_casc_match: cover property (@(posedge core_clk) disable iff (!rst_b) cascade && ev[0]);
    c_event_mode: cover property (@(posedge core_clk) disable iff (!rst_b)
        count_clock_select[3:0] == 4'h0 && ch_tick[0] && run[0]);
    c_wave_toggle: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(wave_out_two));
    c_half_read: cover property (@(posedge core_clk) disable iff (!rst_b) bus_rd && bus_half);
endmodule : dtc_timer

/* File: verif/dtc_pin_model.sv */
`timescale 1ns/1ns
module dtc_pin_model (
    // event pins toward the timer
    output logic event_one,
    output logic event_two
);
    initial begin
        event_one = 1'b0;
        event_two = 1'b0;
    end

    // pulses of three core cycles high and low, slower than the pin synchroniser
    task automatic send_pulses(input int ch, input int n);
        for (int i = 0; i < n; i++) begin
            #30;
            if (ch == 1) event_one = 1'b1; else event_two = 1'b1;
            #30;
            if (ch == 1) event_one = 1'b0; else event_two = 1'b0;
        end
    endtask : send_pulses
endmodule : dtc_pin_model

/* File: verif/dtc_timer_test.sv */
`timescale 1ns/1ns
module dtc_timer_test;
    import dtc_pkg::*;
    logic              core_clk;
    logic              rst_b;
    logic [ADDR_W-1:0] bus_addr;
    logic              bus_wr;
    logic              bus_rd;
    logic              bus_half;
    logic [BUS_W-1:0]  bus_wdata;
    logic [BUS_W-1:0]  bus_rdata;
    logic              bus_rvalid;
    logic              event_in_one;
    logic              event_in_two;
    logic              wave_out_one;
    logic              wave_out_two;
    logic              match_irq_one;
    logic              match_irq_two;
    int                err_total;
    int                check_count;
    int                gap;

    dtc_timer dut_u (.core_clk, .rst_b, .bus_addr, .bus_wr, .bus_rd, .bus_half, .bus_wdata, .bus_rdata,
        .bus_rvalid, .event_in_one, .event_in_two, .wave_out_one, .wave_out_two, .match_irq_one,
        .match_irq_two);
    dtc_pin_model pm_u (.event_one(event_in_one), .event_two(event_in_two));

    always #5 core_clk = ~core_clk;

    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic check_reg(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: reg got %h exp %h", $time, got, exp);
        end
    endtask : check_reg

    task automatic check_gap(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            err_total++;
            $display("Error at %0t: gap got %h exp %h", $time, got, exp);
        end
    endtask : check_gap

    task automatic check_pin(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: pin got %h exp %h", $time, got, exp);
        end
    endtask : check_pin

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d, input logic half);
        @(negedge core_clk);
        bus_addr  = a;
        bus_wdata = d;
        bus_half  = half;
        bus_wr    = 1'b1;
        @(negedge core_clk);
        bus_wr    = 1'b0;
    endtask : reg_write

    task automatic read_check(input logic [ADDR_W-1:0] a, input logic half, input logic [BUS_W-1:0] exp);
        @(negedge core_clk);
        bus_addr = a;
        bus_half = half;
        bus_rd   = 1'b1;
        @(negedge core_clk);
        bus_rd   = 1'b0;
        check_reg((bus_rvalid === 1'b1) ? bus_rdata : 'x, exp);
    endtask : read_check

    // cycles between two irq pulses or two wave edges of the chosen channel
    task automatic measure(input logic use_wave, input logic ch_two, output int n);
        logic prev;
        logic cur;
        int   seen;
        int   t;
        seen = 0;
        n    = 0;
        t    = 0;
        prev = ch_two ? wave_out_two : wave_out_one;
        while (seen < 2 && t < 30000) begin
            @(negedge core_clk);
            t++;
            if (seen == 1) n++;
            cur = ch_two ? wave_out_two : wave_out_one;
            if (use_wave ? (cur !== prev) : ((ch_two ? match_irq_two : match_irq_one) === 1'b1)) seen++;
            prev = cur;
        end
    endtask : measure

    initial begin
        #600000;
        err_total++;
        complete_run();
    end

    initial begin
        core_clk  = 1'b0;
        rst_b     = 1'b0;
        bus_addr  = '0;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_half  = 1'b0;
        bus_wdata = '0;
        err_total = 0;
        check_count = 0;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        read_check(OFS_COUNT_ONE, 1'b0, 16'h0000);
        read_check(OFS_COUNT_TWO, 1'b0, 16'h0000);
        reg_write(OFS_MATCH_ONE, 16'h0000, 1'b0);
        read_check(OFS_MATCH_ONE, 1'b0, 16'h0000);
        reg_write(OFS_MATCH_ONE, 16'h00ff, 1'b0);
        read_check(OFS_MATCH_ONE, 1'b0, 16'h00ff);
        reg_write(OFS_MATCH_ONE, 16'h1234, 1'b1);
        read_check(OFS_MATCH_ONE, 1'b0, 16'h00ff);
        read_check(4'h8, 1'b0, 16'h0000);
        read_check(OFS_MATCH_ONE, 1'b1, 16'h0000);
        reg_write(OFS_OSC_SEL, 16'h0001, 1'b0);
        reg_write(OFS_MATCH_ONE, 16'h0002, 1'b0);
        for (int c = 6; c < 16; c++) begin
            reg_write(OFS_MODE_CTL, 16'h0000, 1'b0);
            reg_write(OFS_CLK_SEL, 16'(c), 1'b0);
            reg_write(OFS_MODE_CTL, 16'h0001, 1'b0);
            measure(1'b0, 1'b0, gap);
            check_gap(gap, 3 * ((c == 15) ? 2048 : (1 << (c - 5))));
        end
        reg_write(OFS_MODE_CTL, 16'h0000, 1'b0);
        reg_write(OFS_CLK_SEL, 16'h0002, 1'b0);
        reg_write(OFS_MODE_CTL, 16'h0001, 1'b0);
        repeat (40) @(negedge core_clk);
        read_check(OFS_COUNT_ONE, 1'b0, 16'h0000);
        reg_write(OFS_MODE_CTL, 16'h0000, 1'b0);
        reg_write(OFS_CLK_SEL, 16'h0006, 1'b0);
        reg_write(OFS_OSC_SEL, 16'h0000, 1'b0);
        reg_write(OFS_MODE_CTL, 16'h0001, 1'b0);
        measure(1'b0, 1'b0, gap);
        check_gap(gap, 12);
        reg_write(OFS_WAVE_CTL, 16'h0003, 1'b0);
        measure(1'b1, 1'b0, gap);
        check_gap(gap, 12);
        reg_write(OFS_MODE_CTL, 16'h0000, 1'b0);
        reg_write(OFS_WAVE_CTL, 16'h0005, 1'b0);
        @(negedge core_clk);
        check_pin(wave_out_one, 1'b1);
        read_check(OFS_WAVE_CTL, 1'b0, 16'h0001);
        reg_write(OFS_WAVE_CTL, 16'h0009, 1'b0);
        @(negedge core_clk);
        check_pin(wave_out_one, 1'b0);
        read_check(OFS_WAVE_CTL, 1'b0, 16'h0001);
        reg_write(OFS_MATCH_TWO, 16'h0002, 1'b0);
        reg_write(OFS_CLK_SEL, 16'h0060, 1'b0);
        reg_write(OFS_WAVE_CTL, 16'h0030, 1'b0);
        reg_write(OFS_MODE_CTL, 16'h0002, 1'b0);
        measure(1'b0, 1'b1, gap);
        check_gap(gap, 12);
        measure(1'b1, 1'b1, gap);
        check_gap(gap, 12);
        reg_write(OFS_MODE_CTL, 16'h0000, 1'b0);
        reg_write(OFS_MATCH_ONE, 16'h00ff, 1'b0);
        reg_write(OFS_MATCH_TWO, 16'h00ff, 1'b0);
        reg_write(OFS_CLK_SEL, 16'h0010, 1'b0);
        reg_write(OFS_MODE_CTL, 16'h0003, 1'b0);
        pm_u.send_pulses(2, 3);
        pm_u.send_pulses(1, 2);
        repeat (6) @(negedge core_clk);
        read_check(OFS_COUNT_ONE, 1'b0, 16'h0002);
        read_check(OFS_COUNT_TWO, 1'b0, 16'h0003);
        // stop, load, then run through channel one only
        reg_write(OFS_MODE_CTL, 16'h0000, 1'b0);
        reg_write(OFS_CLK_SEL, 16'h0001, 1'b0);
        reg_write(OFS_MODE_CTL, 16'h0005, 1'b0);
        pm_u.send_pulses(1, 258);
        repeat (6) @(negedge core_clk);
        read_check(OFS_COUNT_ONE, 1'b1, 16'h0102);
        reg_write(OFS_MODE_CTL, 16'h0000, 1'b0);
        reg_write(OFS_MATCH_ONE, 16'h0003, 1'b0);
        reg_write(OFS_MATCH_TWO, 16'h0001, 1'b0);
        reg_write(OFS_CLK_SEL, 16'h0006, 1'b0);
        reg_write(OFS_WAVE_CTL, 16'h0003, 1'b0);
        reg_write(OFS_MODE_CTL, 16'h0005, 1'b0);
        measure(1'b1, 1'b0, gap);
        check_gap(gap, 16'h0104 * 4);
        complete_run();
    end
endmodule : dtc_timer_test
